// [src/tsc_pkg.sv]
package tsc_pkg;

    // ******************************************************************
    // Control byte layout
    // ******************************************************************
    localparam int unsigned CTL_START    = 7;
    localparam int unsigned CTL_CHAN_HI  = 6;
    localparam int unsigned CTL_CHAN_LO  = 4;
    localparam int unsigned CTL_MODE     = 3;
    localparam int unsigned CTL_REF_MODE = 2;
    localparam int unsigned CTL_REF_PWR  = 1;
    localparam int unsigned CTL_ADC_PWR  = 0;

    // ******************************************************************
    // Serial sequencing counts
    // ******************************************************************
    localparam logic [2:0] BITS_CHAN_KNOWN = 3'h2;
    localparam logic [2:0] BITS_ACQ_START  = 3'h3;
    localparam logic [2:0] BITS_SER_KNOWN  = 3'h4;
    localparam logic [2:0] BITS_BYTE_LAST  = 3'h6;
    localparam logic [3:0] RES_12          = 4'hc;
    localparam logic [3:0] RES_8           = 4'h8;
    localparam logic [3:0] OVERLAP_SUB     = 4'h5;
    localparam logic [3:0] CONV_RISE_MAX   = 4'hf;

    // ******************************************************************
    // Channel codes
    // ******************************************************************
    localparam logic [2:0] CHAN_BATTERY = 3'h2;
    localparam logic [2:0] CHAN_Y_POS   = 3'h1;
    localparam logic [2:0] CHAN_Z1      = 3'h3;
    localparam logic [2:0] CHAN_Z2      = 3'h4;
    localparam logic [2:0] CHAN_X_POS   = 3'h5;

    // ******************************************************************
    // APB register map and reset values
    // ******************************************************************
    localparam logic [7:0]  REG_CODE     = 8'h00;
    localparam logic [7:0]  REG_STATUS   = 8'h04;
    localparam logic [7:0]  REG_COUNT    = 8'h08;
    localparam logic [11:0] CODE_RST     = 12'h000;
    localparam logic [1:0]  PD_RST       = 2'h0;
    localparam logic [2:0]  SYNC_RST     = 3'h4;
    localparam int unsigned ST_BUSY      = 8;
    localparam int unsigned ST_ACQ       = 9;
    localparam int unsigned ST_CONV      = 10;
    localparam int unsigned ST_REF_ON    = 11;
    localparam int unsigned ST_ADC_ON    = 12;

    typedef enum logic {TSC_IN_IDLE, TSC_IN_CTRL} tsc_in_e;

endpackage : tsc_pkg

// [src/tsc_sync.sv]
`timescale 1ns/100ps
module tsc_sync #(
    parameter int unsigned   W   = 1,
    parameter logic [W-1:0]  RST = '0
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta;

    // The first stage feeds only the second stage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta     <= RST;
            sync_out <= RST;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : tsc_sync

// [src/tsc_serial_ctrl.sv]
`timescale 1ns/100ps
// Overview of operation
// R1: Serial input is ignored until a high start bit arrives.
// R2: Control byte MSB first: start, channel, resolution, reference, power bits.
// R3: Resolution bit low gives 12-bit conversion, high gives 8-bit.
// R4: Reference select high is single-ended, low is ratiometric across drivers.
// R5: Host uses ratiometric mode only for X, Y and pressure channels.
// R6: Byte hosts use three 8-clock transfers, 24 clocks per conversion.
// R7: Acquire three clocks once bits known, then hold; drivers off if single-ended.
// R8: Convert over 12 clocks; ratiometric keeps drivers on through last bit.
// R9: Pad clocks after the result drive output low and are ignored.
// R10: New control byte may start every 15th clock (12-bit) or 11th (8-bit).
// R11: Battery divider on only while acquiring channel code 010.
// R12: Power bits decode converter, reference and pen interrupt enables.
// R13: Power-down mode sleeps after each conversion, wakes instantly, Y- switch on.
// R14: Reference power bit is latched when busy rises.
// R15: Converter needs no wake-up; reference powered independently.
// R16: Host allows reference settling after enabling it.
// R17: Next control bits shift in while result shifts out, 16 clocks each.
// R18: Host finishes each conversion within 1.6 ms of its start.
// R19: Device stays fully powered throughout a conversion, gaps included.
// R20: Chip select high powers down at once and abandons conversion. The code turns only the converter off here and keeps reference_power_on.
// R21: Results are straight binary codes.
// R22: Input sampled on rising serial clock, output updated after falling edge.
// R23: Result shifted out MSB first, one bit per clock after acquisition.
module tsc_serial_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        chip_select_n,
    input  wire logic        serial_clock,
    input  wire logic        serial_data_in,
    output logic             serial_data_out,
    output logic             serial_data_out_oe_n,
    output logic             busy,
    output logic             busy_oe_n,
    output logic [2:0]       channel_select,
    output logic             sample_acquire,
    output logic             touch_drivers_on,
    output logic             battery_divider_on,
    output logic             reference_single_ended,
    output logic             reference_power_on,
    output logic             converter_power_on,
    output logic             pen_touch_interrupt_enable,
    output logic             y_minus_switch_on
);
    import tsc_pkg::*;

    // ******************************************************************
    // Pin synchronisation and serial clock edges
    // ******************************************************************
    logic [2:0]  pins_s;
    logic        cs_s;
    logic        sclk_s;
    logic        din_s;
    logic        sclk_d;
    logic        sclk_rise;
    logic        sclk_fall;

    tsc_sync #(.W(3), .RST(SYNC_RST)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({chip_select_n, serial_clock, serial_data_in}),
        .sync_out (pins_s)
    );

    assign cs_s      = pins_s[2];
    assign sclk_s    = pins_s[1];
    assign din_s     = pins_s[0];
    assign sclk_rise = sclk_s & ~sclk_d & ~cs_s;
    assign sclk_fall = ~sclk_s & sclk_d & ~cs_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
        end
    end

    // ******************************************************************
    // Control byte reception
    // ******************************************************************
    tsc_in_e     in_state;
    logic [2:0]  in_cnt;
    logic [5:0]  in_shift;
    logic [7:0]  last_ctrl;
    logic        mode8;
    logic        single_ended;
    logic [1:0]  pd;
    logic        acquiring;
    logic        converting;
    logic [3:0]  conv_rises;
    logic [3:0]  res_bits;
    logic        start_ok;
    logic        byte_done;
    logic [11:0] code;

    assign res_bits  = mode8 ? RES_8 : RES_12;                               // [R3]
    // Overlap: a start bit is honoured while the previous result still drains.
    // An early start bit is dropped, not queued, so the host must send it again.
    assign start_ok  = !converting || (conv_rises >= res_bits - OVERLAP_SUB); // [R10] [R17]
    assign byte_done = sclk_rise && (in_state == TSC_IN_CTRL) && (in_cnt == BITS_BYTE_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_state       <= TSC_IN_IDLE;
            in_cnt         <= 3'h0;
            in_shift       <= 6'h00;
            last_ctrl      <= 8'h00;
            channel_select <= 3'h0;
            mode8          <= 1'b0;
            single_ended   <= 1'b0;
            pd             <= PD_RST;
            acquiring      <= 1'b0;
        end else if (cs_s) begin
            in_state  <= TSC_IN_IDLE;                                        // [R20]
            in_cnt    <= 3'h0;
            acquiring <= 1'b0;
        end else if (sclk_rise) begin                                        // [R22]
            unique case (in_state)
                TSC_IN_IDLE: begin
                    if (din_s && start_ok) begin                             // [R1]
                        in_state <= TSC_IN_CTRL;
                        in_cnt   <= 3'h0;
                    end
                end
                TSC_IN_CTRL: begin
                    in_shift <= {in_shift[4:0], din_s};                      // [R2]
                    in_cnt   <= in_cnt + 3'h1;
                    if (in_cnt == BITS_CHAN_KNOWN) begin
                        channel_select <= {in_shift[1:0], din_s};
                    end
                    if (in_cnt == BITS_ACQ_START) begin
                        mode8     <= din_s;
                        acquiring <= 1'b1;                                   // [R7]
                    end
                    if (in_cnt == BITS_SER_KNOWN) begin
                        single_ended <= din_s;                               // [R4]
                    end
                    if (in_cnt == BITS_BYTE_LAST) begin
                        pd        <= {in_shift[0], din_s};                   // [R12]
                        last_ctrl <= {1'b1, in_shift, din_s};
                        acquiring <= 1'b0;                                   // [R7]
                        in_state  <= TSC_IN_IDLE;
                    end
                end
            endcase
        end
    end

    // ******************************************************************
    // Conversion and result shifting
    // ******************************************************************
    logic [11:0] out_shift;
    logic [3:0]  out_left;
    logic        busy_pend;
    logic [15:0] conv_count;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_shift       <= 12'h000;
            out_left        <= 4'h0;
            busy_pend       <= 1'b0;
            busy            <= 1'b0;
            converting      <= 1'b0;
            conv_rises      <= 4'h0;
            serial_data_out <= 1'b0;
            conv_count      <= 16'h0000;
        end else if (cs_s) begin
            out_left        <= 4'h0;                                         // [R20]
            busy_pend       <= 1'b0;
            busy            <= 1'b0;
            converting      <= 1'b0;
            serial_data_out <= 1'b0;
        end else if (byte_done) begin
            // Straight binary code; 8-bit results keep the top bits.
            out_shift  <= mode8 ? {code[11:4], 4'h0} : code;                 // [R21] [R3]
            out_left   <= res_bits;                                          // [R8]
            busy_pend  <= 1'b1;
            converting <= 1'b1;
            conv_rises <= 4'h0;
        end else begin
            if (sclk_rise && converting && conv_rises != CONV_RISE_MAX) begin
                conv_rises <= conv_rises + 4'h1;
            end
            if (sclk_fall) begin                                             // [R22]
                if (busy_pend) begin
                    busy_pend       <= 1'b0;
                    busy            <= 1'b1;
                    serial_data_out <= 1'b0;
                end else if (out_left != 4'h0) begin
                    busy            <= 1'b0;
                    serial_data_out <= out_shift[11];                        // [R23]
                    out_shift       <= {out_shift[10:0], 1'b0};
                    out_left        <= out_left - 4'h1;
                    if (out_left == 4'h1) begin
                        converting <= 1'b0;
                        conv_count <= conv_count + 16'h0001;
                    end
                end else begin
                    busy            <= 1'b0;
                    serial_data_out <= 1'b0;                                 // [R9]
                end
            end
        end
    end

    // ******************************************************************
    // Power, reference and analog switch control
    // ******************************************************************
    logic chan_touch;
    logic active;

    assign chan_touch = (channel_select == CHAN_X_POS) || (channel_select == CHAN_Y_POS)
                     || (channel_select == CHAN_Z1) || (channel_select == CHAN_Z2);
    assign active     = acquiring || converting;

    // The reference is left alone by chip select, so it only follows busy.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_power_on <= 1'b0;
        end else if (sclk_fall && busy_pend && !cs_s) begin
            reference_power_on <= pd[CTL_REF_PWR];                           // [R14] [R15]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_acquire             <= 1'b0;
            touch_drivers_on           <= 1'b0;
            battery_divider_on         <= 1'b0;
            reference_single_ended     <= 1'b0;
            converter_power_on         <= 1'b0;
            pen_touch_interrupt_enable <= 1'b1;
            y_minus_switch_on          <= 1'b0;
            serial_data_out_oe_n       <= 1'b1;
            busy_oe_n                  <= 1'b1;
        end else begin
            sample_acquire             <= acquiring;                         // [R7]
            touch_drivers_on           <= chan_touch                         // [R7] [R8]
                                          && (acquiring || (converting && !single_ended));
            battery_divider_on         <= acquiring && (channel_select == CHAN_BATTERY); // [R11]
            reference_single_ended     <= single_ended;                      // [R4]
            converter_power_on         <= !cs_s && (pd[CTL_ADC_PWR] || active); // [R13] [R19]
            pen_touch_interrupt_enable <= !pd[CTL_ADC_PWR];                  // [R12]
            y_minus_switch_on          <= (pd == 2'h0) && !active;           // [R13]
            serial_data_out_oe_n       <= cs_s;
            busy_oe_n                  <= cs_s;
        end
    end

    // ******************************************************************
    // APB register slave
    // ******************************************************************
    logic apb_acc;

    assign apb_acc = psel && penable;
    assign pready  = 1'b1;
    assign pslverr = apb_acc && (paddr != REG_CODE) && (paddr != REG_STATUS)
                  && (paddr != REG_COUNT);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code <= CODE_RST;
        end else if (apb_acc && pwrite && paddr == REG_CODE) begin
            code <= pwdata[11:0];
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (apb_acc && !pwrite) begin
            unique case (paddr)
                REG_CODE:   prdata[11:0] = code;
                REG_STATUS: begin
                    prdata[7:0]       = last_ctrl;
                    prdata[ST_BUSY]   = busy;
                    prdata[ST_ACQ]    = acquiring;
                    prdata[ST_CONV]   = converting;
                    prdata[ST_REF_ON] = reference_power_on;
                    prdata[ST_ADC_ON] = converter_power_on;
                end
                REG_COUNT:  prdata[15:0] = conv_count;
                default:    prdata = 32'h0000_0000;
            endcase
        end
    end

    // ******************************************************************
    // Assertions and covers
    // ******************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_start_flag_wait: assert property ((in_state == TSC_IN_IDLE) && sclk_rise && !din_s // [R1]
        |=> in_state == TSC_IN_IDLE) else $error("start bit not awaited");
    a_start_refused: assert property ((in_state == TSC_IN_IDLE) && sclk_rise && din_s // [R10]
        && !start_ok |=> in_state == TSC_IN_IDLE) else $error("early start bit honoured");
    a_res_count: assert property (byte_done |=> out_left == (mode8 ? 4'h8 : 4'hc)) // [R3]
        else $error("wrong result length");
    a_ref_mode: assert property (##1 reference_single_ended == $past(single_ended)) // [R4]
        else $error("reference mode mismatch");
    a_acq_in_ctrl: assert property (acquiring |-> in_state == TSC_IN_CTRL) // [R7]
        else $error("acquiring outside control byte");
    a_drv_single_off: assert property (converting && single_ended && !acquiring // [R7]
        |=> !touch_drivers_on) else $error("drivers on while holding single-ended");
    a_drv_ratio_on: assert property (converting && !single_ended && chan_touch // [R8]
        |=> touch_drivers_on) else $error("drivers off during ratiometric conversion");
    a_batt_divider: assert property (battery_divider_on // [R11]
        |-> $past(acquiring) && $past(channel_select) == 3'h2)
        else $error("battery divider outside sampling");
    a_pen_decode: assert property (##1 pen_touch_interrupt_enable == !$past(pd[0])) // [R12]
        else $error("pen interrupt enable mismatch");
    a_y_minus_on: assert property (y_minus_switch_on // [R13]
        |-> $past(pd) == 2'h0 && !$past(active)) else $error("y minus switch on while active");
    a_pad_low: assert property (sclk_fall && !busy_pend && out_left == 4'h0 // [R9]
        |=> !serial_data_out) else $error("pad clock not low");
    a_cs_abort: assert property (cs_s |=> !busy && !converting // [R20]
        && in_state == TSC_IN_IDLE && serial_data_out_oe_n && !converter_power_on)
        else $error("abort failed");
    a_oe_follow_cs: assert property (##1 serial_data_out_oe_n == $past(cs_s) // [R20]
        && busy_oe_n == $past(cs_s)) else $error("output enable does not follow select");
    a_ref_latch: assert property ($rose(busy) |-> reference_power_on == pd[1]) // [R14]
        else $error("reference not latched on busy");
    a_pwr_conv: assert property (converting && !cs_s ##1 !cs_s |-> converter_power_on) // [R19]
        else $error("converter off during conversion");
    a_msb_first: assert property (sclk_fall && !busy_pend && out_left != 4'h0 // [R23]
        |=> serial_data_out == $past(out_shift[11])) else $error("bit order wrong");
    a_busy_one_clk: assert property (busy && sclk_fall |=> !busy) // [R8]
        else $error("busy longer than one clock");

    c_refused: cover property (sclk_rise && in_state == TSC_IN_IDLE && din_s && !start_ok);
    c_conv_12: cover property (byte_done && !mode8);
    c_conv_8: cover property (byte_done && mode8);
    c_overlap: cover property (sclk_rise && in_state == TSC_IN_IDLE && din_s && converting);
    c_abort: cover property (converting && cs_s);

endmodule : tsc_serial_ctrl

// [sim/tsc_host_model.sv]
`timescale 1ns/100ps
module tsc_host_model (
    input  wire logic pclk,
    input  wire logic serial_data_out,
    input  wire logic serial_data_out_oe_n,
    output logic      chip_select_n,
    output logic      serial_clock,
    output logic      serial_data_in
);
    initial begin
        chip_select_n  = 1'b1;
        serial_clock   = 1'b0;
        serial_data_in = 1'b0;
    end

    // ******************************************************************
    // Frame control
    // ******************************************************************
    task automatic frame_open;
        @(posedge pclk);
        chip_select_n <= 1'b0;
        // Idle time after opening also lets a freshly enabled reference settle.
        repeat (20) @(posedge pclk);
    endtask : frame_open

    // The released data line flips, so a stale level is never mistaken for data.
    task automatic frame_close;
        @(posedge pclk);
        chip_select_n  <= 1'b1;
        serial_data_in <= ~serial_data_in;
        repeat (20) @(posedge pclk);
    endtask : frame_close

    // ******************************************************************
    // Bit transfer: 13 cycles low and 12 high make a 125 ns serial clock
    // ******************************************************************
    // The clock only runs inside a frame, and sits low between bits.
    task automatic shift(input logic [47:0] tx, input int n, output logic [47:0] rx);
        rx = '0;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge pclk);
            serial_data_in <= tx[i];
            repeat (12) @(posedge pclk);
            rx = {rx[46:0], serial_data_out_oe_n ? 1'bx : serial_data_out};
            serial_clock <= 1'b1;
            repeat (12) @(posedge pclk);
            serial_clock <= 1'b0;
        end
    endtask : shift
endmodule : tsc_host_model

// [sim/tsc_serial_ctrl_test.sv]
`timescale 1ns/100ps
module tsc_serial_ctrl_test;
    import tsc_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cs_n;
    logic        sclk;
    logic        din;
    logic        dout;
    logic        dout_oe_n;
    logic        busy;
    logic        busy_oe_n;
    logic [2:0]  chan;
    logic        acq;
    logic        drv_on;
    logic        batt_on;
    logic        ref_se;
    logic        ref_on;
    logic        adc_on;
    logic        pen_en;
    logic        ym_on;
    logic        seen_batt = 1'b0;
    logic        seen_acq = 1'b0;
    logic        seen_busy = 1'b0;
    logic        seen_drv = 1'b0;
    logic [31:0] rd;
    logic [47:0] rx;
    int          err_total = 0;
    int          total_checks = 0;

    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        if (batt_on === 1'b1) seen_batt <= 1'b1;
        if (acq === 1'b1) seen_acq <= 1'b1;
        if (busy === 1'b1) seen_busy <= 1'b1;
        if (drv_on === 1'b1) seen_drv <= 1'b1;
    end

    tsc_serial_ctrl u_tsc_serial_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_select_n(cs_n),
        .serial_clock(sclk), .serial_data_in(din), .serial_data_out(dout),
        .serial_data_out_oe_n(dout_oe_n), .busy(busy), .busy_oe_n(busy_oe_n),
        .channel_select(chan), .sample_acquire(acq), .touch_drivers_on(drv_on),
        .battery_divider_on(batt_on), .reference_single_ended(ref_se),
        .reference_power_on(ref_on), .converter_power_on(adc_on),
        .pen_touch_interrupt_enable(pen_en), .y_minus_switch_on(ym_on));
    tsc_host_model u_tsc_host_model (.pclk(pclk), .serial_data_out(dout),
        .serial_data_out_oe_n(dout_oe_n), .chip_select_n(cs_n), .serial_clock(sclk),
        .serial_data_in(din));

    // ******************************************************************
    // Shared tasks
    // ******************************************************************
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] data);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        data = prdata;
        if (a > REG_COUNT) check("pslverr", pslverr, 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    // A full run needs about 4000 cycles; five times that means a hang.
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        report_and_stop();
    end

    // ******************************************************************
    // Tests
    // ******************************************************************
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        check("pen_en", pen_en, 1'b1);
        apb(1'b0, REG_COUNT, 32'h0, rd);
        check("count", rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        apb(1'b1, REG_CODE, 32'h00000a5c, rd);
        $display("test reset and registers done");

        u_tsc_host_model.frame_open();
        u_tsc_host_model.shift({24'h0, 8'haf, 16'h0}, 24, rx);
        check("batt result", rx, {24'h0, 9'h0, 8'ha5, 7'h0});
        check("batt divider", seen_batt, 1'b1);
        check("acquire seen", seen_acq, 1'b1);
        check("busy seen", seen_busy, 1'b1);
        check("drivers idle", seen_drv, 1'b0);
        apb(1'b0, REG_STATUS, 32'h0, rd);
        check("status on", rd, 32'h000018af);
        check("pen off", pen_en, 1'b0);
        check("single ended", ref_se, 1'b1);
        u_tsc_host_model.shift({40'h0, 8'hd3}, 12, rx);
        u_tsc_host_model.frame_close();
        apb(1'b0, REG_COUNT, 32'h0, rd);
        check("count abort", rd, 32'h1);
        check("adc after abort", adc_on, 1'b0);
        check("ref kept", ref_on, 1'b1);
        check("dout released", dout_oe_n, 1'b1);
        check("busy released", busy_oe_n, 1'b1);
        check("busy abort", busy, 1'b0);
        check("drivers used", seen_drv, 1'b1);
        $display("test eight bit and abort done");

        u_tsc_host_model.frame_open();
        u_tsc_host_model.shift({24'h0, 8'hd0, 8'h08, 8'h00}, 24, rx);
        check("x result", rx, {24'h0, 9'h0, 12'ha5c, 3'h0});
        check("ratiometric", ref_se, 1'b0);
        check("channel", chan, CHAN_X_POS);
        apb(1'b0, REG_STATUS, 32'h0, rd);
        check("status off", rd, 32'h000000d0);
        check("y minus", ym_on, 1'b1);
        check("pen on", pen_en, 1'b1);
        check("drivers off", drv_on, 1'b0);
        $display("test twelve bit done");

        u_tsc_host_model.shift({8'hd3, 8'h00, 8'hd3, 24'h0}, 48, rx);
        check("16 clock", rx, {9'h0, 12'ha5c, 4'h0, 12'ha5c, 11'h0});
        u_tsc_host_model.shift({3'h0, 8'hd3, 7'h00, 8'hd3, 22'h0}, 45, rx);
        check("15 clock", rx, {3'h0, 9'h0, 12'ha5c, 3'h0, 12'ha5c, 9'h0});
        u_tsc_host_model.frame_close();
        apb(1'b0, REG_COUNT, 32'h0, rd);
        check("count overlap", rd, 32'h6);
        $display("test overlap done");
        report_and_stop();
    end
endmodule : tsc_serial_ctrl_test
